// ===== can_rx_buffer_lock_release_tb.sv
// Self-checking bench for the receive buffer lock and release logic.
// Assumes the host model drives the bus and the bench drives the receive side.
`timescale 1ns/1ps
module can_rx_buffer_lock_release_tb;
    import crlr_pkg::*;
    logic mclk, rst, sel_active, rx_frame_valid, cpu_rd, cpu_wr, cpu_csw_sel, cpu_data_sel, cpu_timer_sel;
    logic rd_valid_reg, lock_valid_reg, stage_valid_reg, mb_wr_reg, rx_irq_reg;
    logic [3:0] cpu_idx, rx_frame_idx, rd_code_reg, lock_idx_reg, mb_wr_idx_reg, rx_irq_idx_reg, irq_idx, exp_idx;
    logic [1:0] mb_wr_word_reg;
    logic [15:0] buf_active_reg;
    int n_mismatch = 0;
    int checks_done = 0;
    int wr_cnt = 0;
    int irq_cnt = 0;

    crlr_host_model crlr_host_model_i (.mclk(mclk), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_csw_sel(cpu_csw_sel),
        .cpu_data_sel(cpu_data_sel), .cpu_timer_sel(cpu_timer_sel), .cpu_idx(cpu_idx));
    crlr_top crlr_top_i (.mclk(mclk), .rst(rst), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_csw_sel(cpu_csw_sel),
        .cpu_data_sel(cpu_data_sel), .cpu_timer_sel(cpu_timer_sel), .cpu_idx(cpu_idx), .sel_active(sel_active),
        .rx_frame_valid(rx_frame_valid), .rx_frame_idx(rx_frame_idx), .rd_valid_reg(rd_valid_reg),
        .rd_code_reg(rd_code_reg), .lock_valid_reg(lock_valid_reg), .lock_idx_reg(lock_idx_reg),
        .stage_valid_reg(stage_valid_reg), .mb_wr_reg(mb_wr_reg), .mb_wr_idx_reg(mb_wr_idx_reg),
        .mb_wr_word_reg(mb_wr_word_reg), .rx_irq_reg(rx_irq_reg), .rx_irq_idx_reg(rx_irq_idx_reg),
        .buf_active_reg(buf_active_reg));

    // ****************************************
    // Clock, monitor and helpers
    // ****************************************
    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    task automatic chk(input string m, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic test_done();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(negedge mclk) begin
        if (mb_wr_reg) begin
            chk("word order", mb_wr_word_reg, wr_cnt[1:0]);
            chk("word target", mb_wr_idx_reg, exp_idx);
            wr_cnt++;
        end
        if (rx_irq_reg) begin
            irq_cnt++;
            irq_idx = rx_irq_idx_reg;
        end
    end
    task automatic cyc(input int n); repeat (n) @(negedge mclk); endtask
    // Counters restart with every frame so each scenario judges only its own traffic.
    task automatic frame(input logic [3:0] idx);
        @(negedge mclk);
        wr_cnt = 0;
        irq_cnt = 0;
        exp_idx = idx;
        rx_frame_valid = 1'h1;
        rx_frame_idx = idx;
        @(negedge mclk);
        rx_frame_valid = 1'h0;
        rx_frame_idx = ~idx;
    endtask
    task automatic rd(input logic [3:0] idx, input logic [3:0] code);
        crlr_host_model_i.csw_rd(idx);
        chk("read strobe", rd_valid_reg, 1'h1);
        chk("read code", rd_code_reg, code);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        chk("lock after reset", lock_valid_reg, CRLR_LOCK_RST);
        chk("stage after reset", stage_valid_reg, CRLR_STAGE_RST);
        chk("active after reset", buf_active_reg, {16{CRLR_ACTIVE_RST}});
    endtask
    task automatic t_move();
        crlr_host_model_i.csw_wr(4'h5);
        frame(4'h5);
        cyc(8);
        chk("move words", wr_cnt, 16'h4);
        chk("move irq", {irq_cnt[3:0], irq_idx}, 8'h15);
        rd(4'h5, CRLR_CODE_FULL);
        chk("lock set", {lock_valid_reg, lock_idx_reg}, 5'h15);
        rd(4'h6, CRLR_CODE_INACTIVE);
        chk("lock moved", {lock_valid_reg, lock_idx_reg}, 5'h16);
        crlr_host_model_i.tmr_rd();
        chk("lock cleared", lock_valid_reg, 1'h0);
    endtask
    task automatic t_lock();
        crlr_host_model_i.csw_wr(4'h5);
        rd(4'h5, CRLR_CODE_EMPTY);
        frame(4'h5);
        frame(4'h5);
        cyc(8);
        chk("frame held", stage_valid_reg, 1'h1);
        chk("no write while locked", wr_cnt, 16'h0);
        crlr_host_model_i.tmr_rd();
        cyc(8);
        chk("released frame", wr_cnt, 16'h4);
        chk("one frame kept", irq_cnt, 16'h1);
        chk("staging empty", stage_valid_reg, 1'h0);
    endtask
    task automatic t_busy();
        crlr_host_model_i.csw_wr(4'h7);
        frame(4'h7);
        rd(4'h7, CRLR_CODE_BUSY);
        chk("no lock on busy", lock_valid_reg, 1'h0);
        cyc(6);
        rd(4'h7, CRLR_CODE_FULL);
        crlr_host_model_i.tmr_rd();
    endtask
    task automatic t_abort();
        crlr_host_model_i.csw_wr(4'h9);
        sel_active = 1'h1;
        frame(4'h9);
        cyc(1);
        crlr_host_model_i.csw_wr(4'h9);
        cyc(8);
        chk("halted irq", irq_cnt, 16'h0);
        chk("halted move", 16'(wr_cnt < 4), 16'h1);
        chk("deactivated", buf_active_reg[9], 1'h0);
        frame(4'h9);
        cyc(8);
        chk("inactive drops", wr_cnt, 16'h0);
        sel_active = 1'h0;
    endtask
    task automatic t_datawr();
        crlr_host_model_i.csw_wr(4'ha);
        frame(4'ha);
        cyc(1);
        crlr_host_model_i.data_wr(4'ha);
        cyc(8);
        chk("no irq on data write", irq_cnt, 16'h0);
        rd(4'ha, CRLR_CODE_FULL);
        crlr_host_model_i.tmr_rd();
        // A clean frame into the still full buffer turns it into an overrun.
        frame(4'ha);
        cyc(8);
        chk("irq after clean move", irq_cnt, 16'h1);
        rd(4'ha, CRLR_CODE_OVERRUN);
        crlr_host_model_i.tmr_rd();
    endtask

    initial begin
        rst = 1'h1;
        sel_active = 1'h0;
        rx_frame_valid = 1'h0;
        rx_frame_idx = 4'h0;
        irq_idx = 4'h0;
        cyc(8);
        rst = 1'h0;
        t_reset();
        t_move();
        t_lock();
        t_busy();
        t_abort();
        t_datawr();
        test_done();
    end
    // The scenarios need about 126 cycles; the 10000-cycle limit is ample margin.
    initial begin
        #40000;
        n_mismatch++;
        test_done();
    end
endmodule

// ===== crlr_host_model.sv
// Behavioural host core reaching the receive buffers over the internal bus.
// Assumes the bench calls one access at a time; each lasts one strobe cycle.
`timescale 1ns/1ps
module crlr_host_model (
    input wire logic mclk,
    output logic cpu_rd,
    output logic cpu_wr,
    output logic cpu_csw_sel,
    output logic cpu_data_sel,
    output logic cpu_timer_sel,
    output logic [3:0] cpu_idx
);
    // ****************************************
    // Bus access
    // ****************************************
    initial begin
        cpu_rd = 1'h0;
        cpu_wr = 1'h0;
        {cpu_csw_sel, cpu_data_sel, cpu_timer_sel} = 3'h0;
        cpu_idx = 4'h0;
    end
    task automatic acc(input logic rd, input logic wr, input logic [2:0] sel, input logic [3:0] idx);
        @(negedge mclk);
        cpu_rd = rd;
        cpu_wr = wr;
        {cpu_csw_sel, cpu_data_sel, cpu_timer_sel} = sel;
        cpu_idx = idx;
        @(negedge mclk);
        cpu_rd = 1'h0;
        cpu_wr = 1'h0;
        {cpu_csw_sel, cpu_data_sel, cpu_timer_sel} = 3'h0;
        // The index is not held after the strobe, so show something stale-looking.
        cpu_idx = ~idx;
    endtask
    task automatic csw_rd(input logic [3:0] i); acc(1'h1, 1'h0, 3'h4, i); endtask
    task automatic csw_wr(input logic [3:0] i); acc(1'h0, 1'h1, 3'h4, i); endtask
    // Only issued when a scenario deliberately misbehaves.
    task automatic data_wr(input logic [3:0] i); acc(1'h0, 1'h1, 3'h2, i); endtask
    // Every control/status read in the bench is followed by this release.
    task automatic tmr_rd(); acc(1'h1, 1'h0, 3'h1, 4'h0); endtask
endmodule

// ===== crlr_lock.sv
// Tracker of the single buffer lock set by control/status reads.
// Assumes read strobes are one-cycle pulses on the module clock.
`timescale 1ns/1ps
module crlr_lock
    import crlr_pkg::*;
#(
    parameter int IW = 4
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic csw_rd,
    input wire logic csw_rd_busy,
    input wire logic [IW-1:0] rd_idx,
    input wire logic timer_rd,
    output logic lock_valid_reg,
    output logic [IW-1:0] lock_idx_reg
);

    logic lock_valid_next;
    logic [IW-1:0] lock_idx_next;

    always_comb begin
        lock_valid_next = lock_valid_reg;
        lock_idx_next = lock_idx_reg;
        if (timer_rd) begin
            lock_valid_next = 1'b0;
        end else if (csw_rd && !csw_rd_busy) begin
            // Locking a new buffer releases the previous one.
            lock_valid_next = 1'b1;
            lock_idx_next = rd_idx;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lock_valid_reg <= CRLR_LOCK_RST;
            lock_idx_reg <= '0;
        end else begin
            lock_valid_reg <= lock_valid_next;
            lock_idx_reg <= lock_idx_next;
        end
    end

endmodule

// ===== crlr_move.sv
// Sequencer that copies a staged frame into one receive buffer, word by word.
// Assumes the controller only raises start while the sequencer is idle.
`timescale 1ns/1ps
module crlr_move
    import crlr_pkg::*;
#(
    parameter int NUM_WORDS = CRLR_XFER_WORDS
)(
    input wire logic mclk,
    input wire logic rst,
    crlr_move_if.seq mv
);

    initial begin
        if (NUM_WORDS < 2 || NUM_WORDS > (1 << $bits(mv.word))) begin
            $error("crlr_move: NUM_WORDS does not fit the word counter");
        end
    end

    crlr_mv_state_t state_reg, state_next;
    logic [$bits(mv.word)-1:0] cnt_reg, cnt_next;
    logic [$bits(mv.idx)-1:0] idx_reg, idx_next;
    logic done_reg, done_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        idx_next = idx_reg;
        done_next = 1'b0;
        case (state_reg)
            CRLR_MV_IDLE: begin
                if (mv.start) begin
                    state_next = CRLR_MV_COPY;
                    cnt_next = '0;
                    idx_next = mv.idx;
                end
            end
            CRLR_MV_COPY: begin
                if (mv.abort) begin
                    // A halted move leaves mixed data and reports nothing.
                    state_next = CRLR_MV_IDLE;
                end else if (cnt_reg == ($bits(cnt_reg))'(NUM_WORDS - 1)) begin
                    state_next = CRLR_MV_IDLE;
                    done_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            default: begin
                state_next = CRLR_MV_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= CRLR_MV_IDLE;
            cnt_reg <= '0;
            idx_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            idx_reg <= idx_next;
            done_reg <= done_next;
        end
    end

    assign mv.busy = (state_reg == CRLR_MV_COPY);
    assign mv.wr = (state_reg == CRLR_MV_COPY) && !mv.abort;
    assign mv.word = cnt_reg;
    assign mv.cur_idx = idx_reg;
    assign mv.done = done_reg;

endmodule

// ===== crlr_move_if.sv
// Carrier between the coherency top and the frame move sequencer.
// Assumes both ends run on the same module clock.
`timescale 1ns/1ps
interface crlr_move_if #(
    parameter int IW = 4,
    parameter int WW = 2
);
    logic start;
    logic [IW-1:0] idx;
    logic abort;
    logic busy;
    logic [IW-1:0] cur_idx;
    logic [WW-1:0] word;
    logic wr;
    logic done;

    modport ctrl(output start, output idx, output abort,
                 input busy, input cur_idx, input word, input wr, input done);
    modport seq(input start, input idx, input abort,
                output busy, output cur_idx, output word, output wr, output done);
endinterface

// ===== crlr_pkg.sv
// Shared constants and types for the receive buffer lock and release logic.
// Assumes a single module clock and an active-high asynchronous reset.
package crlr_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int CRLR_NUM_BUFS = 16;
    localparam int CRLR_XFER_WORDS = 4;

    // ****************************************
    // Control/status codes returned on a read
    // ****************************************
    localparam logic [3:0] CRLR_CODE_INACTIVE = 4'h0;
    localparam logic [3:0] CRLR_CODE_BUSY = 4'h1;
    localparam logic [3:0] CRLR_CODE_FULL = 4'h2;
    localparam logic [3:0] CRLR_CODE_EMPTY = 4'h4;
    localparam logic [3:0] CRLR_CODE_OVERRUN = 4'h6;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic CRLR_LOCK_RST = 1'b0;
    localparam logic CRLR_ACTIVE_RST = 1'b0;
    localparam logic CRLR_STAGE_RST = 1'b0;

    typedef enum {CRLR_MV_IDLE, CRLR_MV_COPY} crlr_mv_state_t;

endpackage

// ===== crlr_top.sv
// Receive buffer coherency: lock, release, busy and deactivation control.
// Assumes the acceptance filter supplies the matching buffer index with each
// frame, and that host access strobes are one-cycle pulses on mclk.
//
// Overview of operation
// - Control/status write during buffer selection deactivates that buffer at once.
// - Deactivation during a move halts it; no interrupt request follows.
// - Host data write during a move gives full or overrun, no interrupt.
// - Reading a buffer control/status word locks that buffer, unless busy.
// - A locked buffer receives no newly matched frame unless its move starts in the cycle of the locking read.
// - Reading another control/status word not answered with busy, or the timer, releases the lock.
// - A frame for a locked buffer waits in staging, with no indication.
// - On release, a waiting matching frame moves into its buffer.
// - Newer matching frames overwrite the staged one silently.
// - A control/status read during a move into it returns busy.
// - A read answered with busy places no lock.
`timescale 1ns/1ps
module crlr_top
    import crlr_pkg::*;
#(
    parameter int NUM_BUFS = CRLR_NUM_BUFS,
    parameter int XFER_WORDS = CRLR_XFER_WORDS
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic cpu_csw_sel,
    input wire logic cpu_data_sel,
    input wire logic cpu_timer_sel,
    input wire logic [$clog2(NUM_BUFS)-1:0] cpu_idx,
    input wire logic sel_active,
    input wire logic rx_frame_valid,
    input wire logic [$clog2(NUM_BUFS)-1:0] rx_frame_idx,
    output logic rd_valid_reg,
    output logic [3:0] rd_code_reg,
    output logic lock_valid_reg,
    output logic [$clog2(NUM_BUFS)-1:0] lock_idx_reg,
    output logic stage_valid_reg,
    output logic mb_wr_reg,
    output logic [$clog2(NUM_BUFS)-1:0] mb_wr_idx_reg,
    output logic [$clog2(XFER_WORDS)-1:0] mb_wr_word_reg,
    output logic rx_irq_reg,
    output logic [$clog2(NUM_BUFS)-1:0] rx_irq_idx_reg,
    output logic [NUM_BUFS-1:0] buf_active_reg
);

    localparam int IW = $clog2(NUM_BUFS);
    localparam int WW = $clog2(XFER_WORDS);

    // A partly used index range would let a host index address flags that do not exist.
    initial begin
        if (NUM_BUFS < 2 || XFER_WORDS < 2 || (1 << WW) != XFER_WORDS || (1 << IW) != NUM_BUFS) begin
            $error("crlr_top: buffer count or move length not supported");
        end
    end

    // ****************************************
    // Host access decode
    // ****************************************
    logic csw_rd;
    logic csw_wr;
    logic data_wr;
    logic timer_rd;
    logic csw_rd_busy;

    // Only these strobes touch lock state; other reads pass untouched.
    assign csw_rd = cpu_rd && cpu_csw_sel;
    assign timer_rd = cpu_rd && cpu_timer_sel;
    assign csw_wr = cpu_wr && cpu_csw_sel;
    assign data_wr = cpu_wr && cpu_data_sel;

    crlr_move_if #(.IW(IW), .WW(WW)) mv();

    assign csw_rd_busy = csw_rd && mv.busy && (mv.cur_idx == cpu_idx);

    // ****************************************
    // Lock tracking
    // ****************************************
    crlr_lock #(.IW(IW)) u_lock (
        .mclk(mclk),
        .rst(rst),
        .csw_rd(csw_rd),
        .csw_rd_busy(csw_rd_busy),
        .rd_idx(cpu_idx),
        .timer_rd(timer_rd),
        .lock_valid_reg(lock_valid_reg),
        .lock_idx_reg(lock_idx_reg)
    );

    // ****************************************
    // Move sequencer
    // ****************************************
    crlr_move #(.NUM_WORDS(XFER_WORDS)) u_move (
        .mclk(mclk),
        .rst(rst),
        .mv(mv)
    );

    logic stage_valid_next;
    logic [IW-1:0] stage_idx_reg, stage_idx_next;
    logic tainted_reg, tainted_next;
    logic target_locked;
    logic move_start;
    logic move_abort;

    // The lock is re-evaluated every cycle, so a release lets the waiting
    // frame start on the next free cycle without any host action.
    assign target_locked = lock_valid_reg && (lock_idx_reg == stage_idx_reg);
    assign move_start = stage_valid_reg && !mv.busy && !target_locked
                        && buf_active_reg[stage_idx_reg];
    assign move_abort = mv.busy && csw_wr && sel_active && (cpu_idx == mv.cur_idx);

    assign mv.start = move_start;
    assign mv.idx = stage_idx_reg;
    assign mv.abort = move_abort;

    // ****************************************
    // Staging buffer and move bookkeeping
    // ****************************************
    always_comb begin
        stage_valid_next = stage_valid_reg;
        stage_idx_next = stage_idx_reg;
        tainted_next = tainted_reg;
        if (move_start) begin
            stage_valid_next = 1'b0;
            tainted_next = 1'b0;
        end else if (stage_valid_reg && !buf_active_reg[stage_idx_reg]) begin
            // A frame for a buffer that left reception has nowhere to go.
            stage_valid_next = 1'b0;
        end
        if (rx_frame_valid) begin
            // A new frame replaces whatever waited before it.
            stage_valid_next = 1'b1;
            stage_idx_next = rx_frame_idx;
        end
        if (mv.busy && data_wr && (cpu_idx == mv.cur_idx)) begin
            tainted_next = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage_valid_reg <= CRLR_STAGE_RST;
            stage_idx_reg <= '0;
            tainted_reg <= 1'b0;
        end else begin
            stage_valid_reg <= stage_valid_next;
            stage_idx_reg <= stage_idx_next;
            tainted_reg <= tainted_next;
        end
    end

    // ****************************************
    // Per-buffer state
    // ****************************************
    logic [NUM_BUFS-1:0] full_reg;
    logic [NUM_BUFS-1:0] ovr_reg;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BUFS; gi++) begin : g_buf
            logic active_next;
            logic full_next;
            logic ovr_next;
            logic hit_host;
            logic hit_done;

            assign hit_host = (cpu_idx == IW'(gi));
            assign hit_done = mv.done && (mv.cur_idx == IW'(gi));

            always_comb begin
                active_next = buf_active_reg[gi];
                full_next = full_reg[gi];
                ovr_next = ovr_reg[gi];
                if (hit_done) begin
                    // An earlier frame not cleared by a re-arming write turns the new one into an overrun.
                    ovr_next = full_reg[gi] | ovr_reg[gi];
                    full_next = 1'b1;
                end
                if (csw_wr && hit_host) begin
                    if (sel_active) begin
                        active_next = 1'b0;
                    end else begin
                        // A frame landing in the arming cycle is kept, not wiped.
                        active_next = 1'b1;
                        full_next = hit_done;
                        ovr_next = 1'b0;
                    end
                end
            end

            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    buf_active_reg[gi] <= CRLR_ACTIVE_RST;
                    full_reg[gi] <= 1'b0;
                    ovr_reg[gi] <= 1'b0;
                end else begin
                    buf_active_reg[gi] <= active_next;
                    full_reg[gi] <= full_next;
                    ovr_reg[gi] <= ovr_next;
                end
            end
        end
    endgenerate

    // ****************************************
    // Host read answer
    // ****************************************
    logic rd_valid_next;
    logic [3:0] rd_code_next;

    // The code reads zero between answers, so a late sample of the port
    // shows nothing rather than a stale status.
    // Busy is only reported for the buffer under the sequencer; a read of
    // any other buffer during a move still locks normally.
    always_comb begin
        rd_valid_next = csw_rd;
        rd_code_next = CRLR_CODE_EMPTY;
        if (csw_rd_busy) begin
            rd_code_next = CRLR_CODE_BUSY;
        end else if (!buf_active_reg[cpu_idx]) begin
            rd_code_next = CRLR_CODE_INACTIVE;
        end else if (ovr_reg[cpu_idx]) begin
            rd_code_next = CRLR_CODE_OVERRUN;
        end else if (full_reg[cpu_idx]) begin
            rd_code_next = CRLR_CODE_FULL;
        end
        if (!csw_rd) begin
            rd_code_next = '0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_valid_reg <= 1'b0;
            rd_code_reg <= '0;
        end else begin
            rd_valid_reg <= rd_valid_next;
            rd_code_reg <= rd_code_next;
        end
    end

    // ****************************************
    // Buffer writes and interrupt request
    // ****************************************
    logic mb_wr_next;
    logic [IW-1:0] mb_wr_idx_next;
    logic [WW-1:0] mb_wr_word_next;
    logic rx_irq_next;
    logic [IW-1:0] rx_irq_idx_next;

    // These ports trail the sequencer by one cycle so that each leaves a
    // flip-flop; the buffer storage must accept the same one-cycle delay.
    always_comb begin
        mb_wr_next = mv.wr;
        mb_wr_idx_next = mv.cur_idx;
        mb_wr_word_next = mv.word;
        // A host data write during the move spoils the frame: no request.
        rx_irq_next = mv.done && !tainted_reg;
        rx_irq_idx_next = mv.cur_idx;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mb_wr_reg <= 1'b0;
            mb_wr_idx_reg <= '0;
            mb_wr_word_reg <= '0;
            rx_irq_reg <= 1'b0;
            rx_irq_idx_reg <= '0;
        end else begin
            mb_wr_reg <= mb_wr_next;
            mb_wr_idx_reg <= mb_wr_idx_next;
            mb_wr_word_reg <= mb_wr_word_next;
            rx_irq_reg <= rx_irq_next;
            rx_irq_idx_reg <= rx_irq_idx_next;
        end
    end

endmodule

// ===== crlr_top_assertions.sv
// Concurrent checks on the ports of the receive buffer coherency top.
// Assumes one module clock and is bound to every instance of crlr_top.
`timescale 1ns/1ps
module crlr_top_assertions
    import crlr_pkg::*;
#(
    parameter int NUM_BUFS = CRLR_NUM_BUFS,
    parameter int XFER_WORDS = CRLR_XFER_WORDS
)(
    input wire logic mclk,
    input wire logic rst,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic cpu_csw_sel,
    input wire logic cpu_data_sel,
    input wire logic cpu_timer_sel,
    input wire logic [$clog2(NUM_BUFS)-1:0] cpu_idx,
    input wire logic sel_active,
    input wire logic rx_frame_valid,
    input wire logic [$clog2(NUM_BUFS)-1:0] rx_frame_idx,
    input wire logic rd_valid_reg,
    input wire logic [3:0] rd_code_reg,
    input wire logic lock_valid_reg,
    input wire logic [$clog2(NUM_BUFS)-1:0] lock_idx_reg,
    input wire logic stage_valid_reg,
    input wire logic mb_wr_reg,
    input wire logic [$clog2(NUM_BUFS)-1:0] mb_wr_idx_reg,
    input wire logic [$clog2(XFER_WORDS)-1:0] mb_wr_word_reg,
    input wire logic rx_irq_reg,
    input wire logic [$clog2(NUM_BUFS)-1:0] rx_irq_idx_reg,
    input wire logic [NUM_BUFS-1:0] buf_active_reg
);
    // ****************************************
    // Staged frame owner
    // ****************************************
    logic [$clog2(NUM_BUFS)-1:0] stg_idx_reg;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stg_idx_reg <= {$clog2(NUM_BUFS){1'h0}};
        end else if (rx_frame_valid) begin
            stg_idx_reg <= rx_frame_idx;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence csw_rd_s;
        cpu_rd && cpu_csw_sel && !cpu_timer_sel && !cpu_wr;
    endsequence
    sequence abort_s;
        cpu_wr && cpu_csw_sel && sel_active && mb_wr_reg && cpu_idx == mb_wr_idx_reg;
    endsequence
    sequence quiet_s;
        !mb_wr_reg && !rx_irq_reg ##1 (!rx_irq_reg) [*4];
    endsequence

    csw_lock_a: assert property (csw_rd_s |=> rd_valid_reg && (rd_code_reg == CRLR_CODE_BUSY
        || lock_valid_reg && lock_idx_reg == $past(cpu_idx))) else $error("read did not lock");
    timer_rel_a: assert property (cpu_rd && cpu_timer_sel |=> !lock_valid_reg)
        else $error("timer read kept lock");
    busy_nolock_a: assert property (csw_rd_s |=> rd_code_reg != CRLR_CODE_BUSY
        || $stable(lock_valid_reg) && $stable(lock_idx_reg)) else $error("busy read moved lock");
    locked_nowr_a: assert property (mb_wr_reg && mb_wr_word_reg == 0
        |-> !($past(lock_valid_reg) && $past(lock_idx_reg) == mb_wr_idx_reg)) else $error("wrote locked buffer");
    abort_halt_a: assert property (abort_s |=> quiet_s) else $error("move not halted");
    deact_a: assert property (cpu_wr && cpu_csw_sel && sel_active
        |=> !buf_active_reg[$past(cpu_idx)]) else $error("buffer still active");
    stage_hold_a: assert property (stage_valid_reg && lock_valid_reg && lock_idx_reg == stg_idx_reg
        && buf_active_reg[stg_idx_reg] && !cpu_rd && !cpu_wr |=> stage_valid_reg) else $error("staged frame lost");
    release_mv_a: assert property (stage_valid_reg && lock_valid_reg && lock_idx_reg == stg_idx_reg
        && buf_active_reg[stg_idx_reg] && cpu_rd && cpu_timer_sel && !cpu_wr && !rx_frame_valid
        |=> ##[0:8] mb_wr_reg && mb_wr_idx_reg == stg_idx_reg) else $error("released frame not moved");
endmodule

bind crlr_top crlr_top_assertions #(.NUM_BUFS(NUM_BUFS), .XFER_WORDS(XFER_WORDS)) crlr_top_assertions_i (
    .mclk(mclk), .rst(rst), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_csw_sel(cpu_csw_sel),
    .cpu_data_sel(cpu_data_sel), .cpu_timer_sel(cpu_timer_sel), .cpu_idx(cpu_idx),
    .sel_active(sel_active), .rx_frame_valid(rx_frame_valid), .rx_frame_idx(rx_frame_idx),
    .rd_valid_reg(rd_valid_reg), .rd_code_reg(rd_code_reg), .lock_valid_reg(lock_valid_reg),
    .lock_idx_reg(lock_idx_reg), .stage_valid_reg(stage_valid_reg), .mb_wr_reg(mb_wr_reg),
    .mb_wr_idx_reg(mb_wr_idx_reg), .mb_wr_word_reg(mb_wr_word_reg), .rx_irq_reg(rx_irq_reg),
    .rx_irq_idx_reg(rx_irq_idx_reg), .buf_active_reg(buf_active_reg)
);
